// ---- hw/dac_serial_control.sv ----
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dac_ctrl_defs.svh"

module dac_serial_control
	import dac_ctrl_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Serial link pins; the inputs are asynchronous, the outputs come from system-clock flops.
	input wire logic i_link_clk,
	input wire logic i_frame_sel_n,
	input wire logic i_serial_in,
	input wire logic i_async_zero_n,
	output logic o_serial_out,
	output logic o_serial_out_oe_n,
	// Converter state handed to the analog section.
	output dac_state_t o_analog_out,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Order: link clock, frame select, serial in, clear.
	logic [3:0] pin_meta_r; // First stage, read only by the second.
	logic [3:0] pin_sync_r; // Second stage, safe for logic.
	logic link_clk_prev_r; // Last sampled link clock level.
	logic frame_prev_r; // Last sampled frame-select level.

	// Two flops per pin; reset constants only.
	// Reset levels match the idle pins (link clock low, frame and clear high).
	// A mismatch here would show a false link edge right after every reset.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			pin_meta_r <= 4'h5;
			pin_sync_r <= 4'h5;
			link_clk_prev_r <= 1'b0;
			frame_prev_r <= 1'b1;
		end else begin
			pin_meta_r <= {i_link_clk, i_frame_sel_n, i_serial_in, i_async_zero_n};
			pin_sync_r <= pin_meta_r;
			link_clk_prev_r <= pin_sync_r[3];
			frame_prev_r <= pin_sync_r[2];
		end
	end

	wire link_clk_q = pin_sync_r[3];
	wire frame_q = pin_sync_r[2];
	wire serial_in_q = pin_sync_r[1];
	wire clear_act = ~pin_sync_r[0]; // Clear pin held low, synchronised.
	wire link_fall = link_clk_prev_r & ~link_clk_q;
	wire frame_rise = ~frame_prev_r & frame_q;

	// ****************************************
	// Shift register and converter register
	// ****************************************
	logic [15:0] shift_r; // Input shift register, MSB leaves first; see RULE1.
	logic [11:0] code_r; // Conversion register.
	pwr_mode_t mode_r; // Current output mode.
	logic [31:0] ctrl_r; // Software control word.
	logic [31:0] count_r; // Number of accepted updates.

	wire link_en = ctrl_r[`DAC_CTRL_LINK_EN_POS];
	wire regs_clear = i_reset | clear_act;
	// Shift only inside a frame, on the sampled falling link edge.
	wire do_shift = link_fall & ~frame_q & link_en;
	// Latch only on the frame end seen after any clear has released.
	wire do_update = frame_rise & link_en; // see RULE5
	wire [15:0] shift_nxt = {shift_r[14:0], serial_in_q};
	// Top two bits are dropped; the mode pair rides in every word.
	wire [1:0] mode_bits = {shift_r[`DAC_MODE_HI_POS], shift_r[`DAC_MODE_LO_POS]}; // see RULE9

	// Shift on falling link edges, most significant bit first.
	always_ff @(posedge i_sys_clk) begin
		if (regs_clear) begin
			shift_r <= 16'h0000; // see RULE4
		end else if (do_shift) begin
			shift_r <= shift_nxt; // see RULE10
		end
	end

	// A frame end copies code and mode; code loads even when powered down.
	always_ff @(posedge i_sys_clk) begin
		if (regs_clear) begin
			code_r <= 12'h000; // see RULE3
			mode_r <= PD_NORMAL; // see RULE6
			count_r <= 32'h0000_0000;
		end else if (do_update) begin
			code_r <= shift_r[11:0]; // see RULE11 RULE8
			mode_r <= pwr_mode_t'(mode_bits); // see RULE7
			count_r <= count_r + 32'h0000_0001;
		end
	end

	// The clear pin gates the output with no clock in the path.
	// The code is unsigned; the analog side scales it by code over 4096.
	assign o_analog_out.code = code_r & {12{i_async_zero_n}}; // see RULE2
	assign o_analog_out.mode = i_async_zero_n ? mode_r : PD_NORMAL; // see RULE4

	// Serial out echoes input sixteen falling edges later while framed.
	assign o_serial_out = shift_r[15]; // see RULE12
	assign o_serial_out_oe_n = frame_q; // see RULE12

	// ****************************************
	// APB register slave
	// ****************************************
	logic [31:0] prdata_r; // Read data captured in the setup cycle.

	wire hit_status = (i_paddr == `DAC_REG_STATUS);
	wire hit_ctrl = (i_paddr == `DAC_REG_CTRL);
	wire hit_count = (i_paddr == `DAC_REG_COUNT);
	wire hit_any = hit_status | hit_ctrl | hit_count;
	wire apb_setup = i_psel & ~i_penable;
	wire apb_write = i_psel & i_penable & i_pwrite & hit_ctrl;
	wire [31:0] status_word = {18'h0, mode_r, code_r};
	wire [31:0] rd_mux = hit_status ? status_word :
		hit_ctrl ? ctrl_r :
		hit_count ? count_r : 32'h0000_0000;

	// Control survives a clear so software settings are not lost.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ctrl_r <= `DAC_CTRL_RESET;
		end else if (apb_write) begin
			ctrl_r <= {31'h0, i_pwdata[`DAC_CTRL_LINK_EN_POS]};
		end
	end

	// Read data is registered so the bus sees a flop, not the decoder.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			prdata_r <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_r <= rd_mux;
		end
	end

	assign o_prdata = prdata_r;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~hit_any;

	// ****************************************
	// Assertions
	// ****************************************
	property p_clear_zero;
		@(posedge i_sys_clk) disable iff (i_reset)
		!i_async_zero_n |-> (o_analog_out.code == 12'h000);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero output"); // see RULE4

	property p_clear_regs;
		@(posedge i_sys_clk) disable iff (i_reset)
		clear_act |=> (code_r == 12'h000) && (mode_r == PD_NORMAL) && (shift_r == 16'h0000);
	endproperty
	a_clear_regs: assert property (p_clear_regs) else $error("clear left state"); // see RULE3

	property p_update_code;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_update && !clear_act) |=> (code_r == $past(shift_r[11:0]));
	endproperty
	a_update_code: assert property (p_update_code) else $error("code not latched"); // see RULE11

	property p_update_mode;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_update && !clear_act) |=> (mode_r == $past(shift_r[13:12]));
	endproperty
	a_update_mode: assert property (p_update_mode) else $error("mode not latched"); // see RULE7

	property p_hold;
		@(posedge i_sys_clk) disable iff (i_reset)
		(!frame_rise && !clear_act) |=> $stable(code_r) && $stable(mode_r);
	endproperty
	a_hold: assert property (p_hold) else $error("update without frame end"); // see RULE5

	property p_out_idle;
		@(posedge i_sys_clk) disable iff (i_reset)
		frame_q |-> o_serial_out_oe_n;
	endproperty
	a_out_idle: assert property (p_out_idle) else $error("serial out driven idle"); // see RULE12

	property p_shift;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_shift && !clear_act) |=> shift_r == {$past(shift_r[14:0]), $past(serial_in_q)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift step wrong"); // see RULE10

	property p_pd_load;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_update && !clear_act && mode_bits != 2'b00) |=> code_r == $past(shift_r[11:0]);
	endproperty
	a_pd_load: assert property (p_pd_load) else $error("powered-down write lost"); // see RULE8

	property p_no_link;
		@(posedge i_sys_clk) disable iff (i_reset)
		(!link_en && !clear_act) |=> $stable(shift_r);
	endproperty
	a_no_link: assert property (p_no_link) else $error("shift while link disabled"); // see RULE1

	// The clear pin must also force the normal mode, so the output is never left floating.
	property p_mode_zero;
		@(posedge i_sys_clk) disable iff (i_reset)
		!i_async_zero_n |-> (o_analog_out.mode == PD_NORMAL);
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("clear left power-down mode"); // see RULE4

	// Each accepted frame end adds exactly one to the update count.
	property p_count;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_update && !clear_act) |=> (count_r == $past(count_r) + 32'h0000_0001);
	endproperty
	a_count: assert property (p_count) else $error("update count wrong"); // see RULE11

	// Each shift moves the next older bit onto the chained output.
	property p_echo;
		@(posedge i_sys_clk) disable iff (i_reset)
		(do_shift && !clear_act) |=> (o_serial_out == $past(shift_r[14]));
	endproperty
	a_echo: assert property (p_echo) else $error("serial out did not advance"); // see RULE12

endmodule : dac_serial_control
`default_nettype wire

// ---- pkg/dac_ctrl_defs.svh ----
// How it works
// RULE1 - Sixteen-bit frames over three-wire link, chainable
// RULE2 - Twelve-bit code is plain unsigned binary
// RULE3 - Power-up clears registers, output at zero
// RULE4 - Clear pin low zeroes output and registers
// RULE5 - After clear, update only on next frame end
// RULE6 - Mode bits zero means normal conversion
// RULE7 - Modes 01 1k, 10 100k, 11 high-Z
// RULE8 - Code still loads while powered down
// RULE9 - Mode bits travel inside every data word
// RULE10 - MSB first on falling edges, top two ignored
// RULE11 - Frame-select rise latches last sixteen bits
// RULE12 - Serial out high-Z idle, sixteen-cycle echo otherwise
`ifndef DAC_CTRL_DEFS_SVH
`define DAC_CTRL_DEFS_SVH

// ****************************************
// Serial word layout
// ****************************************
`define DAC_WORD_BITS 16
`define DAC_CODE_BITS 12
`define DAC_MODE_HI_POS 13
`define DAC_MODE_LO_POS 12

// ****************************************
// Register offsets and reset values
// ****************************************
`define DAC_REG_STATUS 12'h000
`define DAC_REG_CTRL 12'h004
`define DAC_REG_COUNT 12'h008
`define DAC_CTRL_LINK_EN_POS 0
`define DAC_CTRL_RESET 32'h0000_0001
`define DAC_STATUS_MODE_POS 12

`endif

// ---- pkg/dac_ctrl_pkg.sv ----
package dac_ctrl_pkg;
	// Output modes in the order of the two mode bits of the word.
	typedef enum logic [1:0] {
		PD_NORMAL,
		PD_GND_1K,
		PD_GND_100K,
		PD_HIGH_Z
	} pwr_mode_t;

	// Converter state as seen by the analog section.
	typedef struct packed {
		pwr_mode_t mode;
		logic [11:0] code;
	} dac_state_t;
endpackage : dac_ctrl_pkg

// ---- verification/spi_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Serial host: drives frames with a 320 ns link clock that stands still between frames.
module spi_host_model (
	input wire logic i_sys_clk,
	output logic o_link_clk,
	output logic o_frame_sel_n,
	output logic o_serial_in
);
	initial begin
		o_link_clk = 1'b0;
		o_frame_sel_n = 1'b1;
		o_serial_in = 1'b0;
	end
	// Data moves on the rising link edge, so each falling edge sees it settled.
	task automatic send(input logic [15:0] word);
		o_frame_sel_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (4) @(posedge i_sys_clk);
			o_link_clk <= 1'b1;
			o_serial_in <= word[i];
			repeat (4) @(posedge i_sys_clk);
			o_link_clk <= 1'b0;
		end
		repeat (4) @(posedge i_sys_clk);
		o_frame_sel_n <= 1'b1;
		// The data line is then driven to the opposite of the last bit.
		o_serial_in <= ~word[0];
	endtask : send
endmodule : spi_host_model
`default_nettype wire

// ---- verification/dac_serial_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_serial_control_tb;
	import dac_ctrl_pkg::*;
	// ****************
	// Pins and counters
	// ****************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic zero_n = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic link, frame_n, sdi, ser_out, ser_out_oe_n, pready, pslverr, err;
	logic [31:0] prdata, rd;
	dac_state_t aout;
	logic [15:0] echo = 16'h0;
	logic [15:0] prev = 16'h0;
	int mismatches = 0;
	int num_checks = 0;
	// Rows: serial word and the converter state it should leave.
	logic [15:0] w [5] = '{16'hCFFF, 16'h5123, 16'h6ABC, 16'hB000, 16'h0ABC};
	logic [13:0] e [5] = '{14'h0FFF, 14'h1123, 14'h2ABC, 14'h3000, 14'h0ABC};
	always #20 clk = ~clk;
	spi_host_model spi_host_model_inst (.i_sys_clk(clk), .o_link_clk(link),
		.o_frame_sel_n(frame_n), .o_serial_in(sdi));
	dac_serial_control dac_serial_control_inst (.i_sys_clk(clk), .i_reset(rst),
		.i_link_clk(link), .i_frame_sel_n(frame_n), .i_serial_in(sdi),
		.i_async_zero_n(zero_n), .o_serial_out(ser_out), .o_serial_out_oe_n(ser_out_oe_n),
		.o_analog_out(aout), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr));
	// Collects the chained output at each falling link edge inside a frame.
	always @(negedge link) begin
		if (!frame_n) begin
			echo <= {echo[14:0], ser_out};
			chk("oe_n framed", 14'h0, 14'(ser_out_oe_n));
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk
	// One APB transfer; the wait ends only on pready or the watchdog.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// One idle edge, so a following call never reassigns psel in this step.
		@(posedge clk);
	endtask : apb
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// Watchdog: fires at 200 us; the whole run needs about 42 us.
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reset out", 14'h0, aout);
		for (int i = 0; i < 5; i++) begin
			spi_host_model_inst.send(w[i]);
			repeat (6) @(posedge clk);
			chk("out", e[i], aout);
			chk("echo", prev[13:0], echo[13:0]);
			chk("oe_n", 14'h1, 14'(ser_out_oe_n));
			apb(1'b0, 12'h000, 32'h0);
			chk("status", e[i], rd[13:0]);
			prev = w[i];
		end
		// Link disabled: a frame must leave the output alone.
		apb(1'b1, 12'h004, 32'h0);
		spi_host_model_inst.send(16'h0123);
		repeat (6) @(posedge clk);
		chk("disabled", e[4], aout);
		apb(1'b0, 12'h008, 32'h0);
		chk("count", 14'h5, rd[13:0]);
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("ctrl", 14'h1, rd[13:0]);
		chk("mapped err", 14'h0, 14'(err));
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped", 14'h1, 14'(err));
		zero_n <= 1'b0;
		#1;
		chk("clear", 14'h0, aout);
		repeat (4) @(posedge clk);
		zero_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("after clear", 14'h0, aout);
		apb(1'b0, 12'h000, 32'h0);
		chk("cleared status", 14'h0, rd[13:0]);
		apb(1'b0, 12'h008, 32'h0);
		chk("cleared count", 14'h0, rd[13:0]);
		spi_host_model_inst.send(16'h1555);
		repeat (6) @(posedge clk);
		chk("first frame", 14'h1555, aout);
		// A second reset in mid-run must clear the latched word again.
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reset again", 14'h0, aout);
		apb(1'b0, 12'h000, 32'h0);
		chk("reset status", 14'h0, rd[13:0]);
		stop_test();
	end
endmodule : dac_serial_control_tb
`default_nettype wire
